// ---- core/rgpb_regs.svh ----
// register offsets, field layout, codes and reset values of the gpio bank
// assumes byte-wide registers addressed by an 8-bit offset
`ifndef RGPB_REGS_SVH
`define RGPB_REGS_SVH

// register offsets
`define RGPB_CFG_LOW_OFS     8'h10
`define RGPB_CFG_HIGH_OFS    8'h11
`define RGPB_STAT_A_OFS      8'h1c
`define RGPB_STAT_B_OFS      8'h1d

// per-pin configuration codes
`define RGPB_CODE_OUT_LOW    4'h1
`define RGPB_CODE_OUT_HIGH   4'h9
`define RGPB_CODE_INPUT      4'h3

// status bit positions for pins 0..3
`define RGPB_STAT_B_PIN0     0
`define RGPB_STAT_A_PIN1     7
`define RGPB_STAT_A_PIN2     6
`define RGPB_STAT_A_PIN3     5

// reset values: every pin undriven, default function
`define RGPB_CFG_RST         8'h00
`define RGPB_DATA_RST        8'h00

// synchroniser depth for pin inputs
`define RGPB_SYNC_STAGES     2

`endif

// ---- core/rgpb_pkg.sv ----
// types shared by the gpio bank modules
// assumes nothing beyond a SystemVerilog compiler
package rgpb_pkg;

  // one register access request, local or remote path
  typedef struct packed {
    logic       wr;     // write strobe, one cycle
    logic       rd;     // read strobe, one cycle
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write data
  } rgpb_req_t;

  // read answer, one cycle after the strobe
  typedef struct packed {
    logic       valid;  // read data valid pulse
    logic [7:0] data;   // read data
  } rgpb_rsp_t;

  // decoded pin mode
  typedef enum logic [1:0] {
    RGPB_MODE_OFF,
    RGPB_MODE_LOW,
    RGPB_MODE_HIGH,
    RGPB_MODE_IN
  } rgpb_mode_t;

endpackage

// ---- core/rgpb_pin_cell.sv ----
// one register-only gpio pin: mode decode, input sync, audio override
// assumes pin_in comes from a pad outside the ref_clk domain
`timescale 1ns/1ps
`include "rgpb_regs.svh"

module rgpb_pin_cell #(
  parameter bit SHARED_I2S = 1'b1  // pin doubles as an audio input
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // configuration field from the register file
  input  wire logic [3:0] code,
  // pad side
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  // block side
  output logic            status,
  output logic            i2s_in
);

  logic                 sync1_reg;   // first stage, read only by sync2
  logic                 sync2_reg;   // second stage
  logic                 stat_reg;    // sampled level for status
  logic                 i2s_reg;     // level handed to audio input
  logic                 stat_next;
  logic                 i2s_next;
  rgpb_pkg::rgpb_mode_t mode;

  // code decode; unknown codes leave the pin alone
  always_comb begin
    case (code)
      `RGPB_CODE_OUT_LOW:  mode = rgpb_pkg::RGPB_MODE_LOW;   // R2
      `RGPB_CODE_OUT_HIGH: mode = rgpb_pkg::RGPB_MODE_HIGH;  // R2
      `RGPB_CODE_INPUT:    mode = rgpb_pkg::RGPB_MODE_IN;    // R3
      default:             mode = rgpb_pkg::RGPB_MODE_OFF;   // R7
    endcase
  end

  // drive only from the config flops, no other source
  assign pin_oe  = (mode == rgpb_pkg::RGPB_MODE_LOW) ||
                   (mode == rgpb_pkg::RGPB_MODE_HIGH);     // R1
  assign pin_out = (mode == rgpb_pkg::RGPB_MODE_HIGH);     // R2
  assign status  = stat_reg;
  assign i2s_in  = i2s_reg;

  // next status and audio levels from the synchronised pin
  always_comb begin
    stat_next = (mode == rgpb_pkg::RGPB_MODE_IN) ? sync2_reg : 1'b0; // R3
    // gpio mode takes the pin away from the audio input
    if (SHARED_I2S && (mode != rgpb_pkg::RGPB_MODE_OFF)) begin
      i2s_next = 1'b0; // R4
    end else begin
      i2s_next = sync2_reg;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      stat_reg  <= 1'b0;
      i2s_reg   <= 1'b0;
    end else if (ce) begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      stat_reg  <= stat_next;
      i2s_reg   <= i2s_next;
    end
  end

  // input mode: status trails the pad by three sampled edges
  sequence in_mode_held_s;
    (ce && code == `RGPB_CODE_INPUT) [*4];
  endsequence
  property input_follows_p;
    @(posedge ref_clk) disable iff (!nrst)
    in_mode_held_s |-> (status == $past(pin_in, 3));
  endproperty
  input_status_a: assert property (input_follows_p) // R3
    else $error("status does not follow pin in input mode");

  drive_low_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!nrst)
    (code == `RGPB_CODE_OUT_LOW) |-> (pin_oe && !pin_out))
    else $error("pin not driven low for low code");

  drive_high_a: assert property ( // R2
    @(posedge ref_clk) disable iff (!nrst)
    (code == `RGPB_CODE_OUT_HIGH) |-> (pin_oe && pin_out))
    else $error("pin not driven high for high code");

  undriven_other_a: assert property ( // R7
    @(posedge ref_clk) disable iff (!nrst)
    (code != `RGPB_CODE_OUT_LOW && code != `RGPB_CODE_OUT_HIGH)
      |-> (!pin_oe && !(status && code != `RGPB_CODE_INPUT && $past(ce) &&
           $past(code) == code)))
    else $error("pin driven or sampled under undefined code");

  audio_override_a: assert property ( // R4
    @(posedge ref_clk) disable iff (!nrst)
    (SHARED_I2S && ce && (code == `RGPB_CODE_OUT_LOW ||
     code == `RGPB_CODE_OUT_HIGH || code == `RGPB_CODE_INPUT))
      |=> !i2s_in)
    else $error("audio input not overridden in gpio mode");

  only_regs_drive_a: assert property ( // R1
    @(posedge ref_clk) disable iff (!nrst)
    !$stable(pin_oe) |-> !$stable(code))
    else $error("pin enable moved without a config change");

endmodule

// ---- core/rgpb_top.sv ----
// What this block does
// R1 - pins steered only by local register bits
// R2 - code 1 drives low, code 9 high
// R3 - code 3 samples pin into status bit
// R4 - gpio mode overrides shared audio input
// R5 - local and remote paths both configure, read
// R6 - pin settings and state never sent over link
// R7 - other codes leave pin undriven, default function
//
// register-only gpio bank: config registers, status, two access paths
// assumes the local and remote request strobes are on ref_clk already
`timescale 1ns/1ps
`include "rgpb_regs.svh"

module rgpb_top #(
  parameter int              NUM_PINS   = 4,         // fixed by the map
  parameter logic [3:0]      I2S_SHARED = 4'b1111    // pins shared w/ audio
) (
  // clock, reset, enable
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  // local register access
  input  wire rgpb_pkg::rgpb_req_t loc_req,
  output rgpb_pkg::rgpb_rsp_t      loc_rsp,
  // remote register access from the control channel
  input  wire rgpb_pkg::rgpb_req_t rem_req,
  output rgpb_pkg::rgpb_rsp_t      rem_rsp,
  // pads
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0]      pin_out,
  output logic [NUM_PINS-1:0]      pin_oe,
  // audio input levels after the gpio override
  output logic [NUM_PINS-1:0]      i2s_in
);

  // the field and status layout below only exists for four pins
  if (NUM_PINS != 4) begin : g_bad_pins
    $error("rgpb_top supports exactly four pins");
  end

  logic [7:0]          cfg_low_reg;    // pins 2,3 fields
  logic [7:0]          cfg_high_reg;   // pins 0,1 fields
  logic [7:0]          cfg_low_next;
  logic [7:0]          cfg_high_next;
  logic [15:0]         cfg_all;        // pin i field at 15-4i
  logic [NUM_PINS-1:0] stat_bits;      // per-pin sampled levels
  logic [7:0]          stat_a;
  logic [7:0]          stat_b;
  rgpb_pkg::rgpb_rsp_t loc_rsp_reg;
  rgpb_pkg::rgpb_rsp_t rem_rsp_reg;
  rgpb_pkg::rgpb_rsp_t loc_rsp_next;
  rgpb_pkg::rgpb_rsp_t rem_rsp_next;

  // read mux, shared by both access paths; unmapped reads give zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic [7:0] sa,
                                          input logic [7:0] sb);
    logic [7:0] d;
    d = `RGPB_DATA_RST;
    if (addr == `RGPB_CFG_LOW_OFS) begin
      d = lo;
    end else if (addr == `RGPB_CFG_HIGH_OFS) begin
      d = hi;
    end else if (addr == `RGPB_STAT_A_OFS) begin
      d = sa;
    end else if (addr == `RGPB_STAT_B_OFS) begin
      d = sb;
    end
    return d;
  endfunction

  // write hit test, shared by both paths and both config registers
  function automatic logic wr_hit(input rgpb_pkg::rgpb_req_t r,
                                  input logic [7:0]          ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  assign cfg_all = {cfg_high_reg, cfg_low_reg};

  // status layout; unlisted bits read as zero
  always_comb begin
    stat_a                     = `RGPB_DATA_RST;
    stat_b                     = `RGPB_DATA_RST;
    stat_b[`RGPB_STAT_B_PIN0]  = stat_bits[0]; // R3
    stat_a[`RGPB_STAT_A_PIN1]  = stat_bits[1]; // R3
    stat_a[`RGPB_STAT_A_PIN2]  = stat_bits[2]; // R3
    stat_a[`RGPB_STAT_A_PIN3]  = stat_bits[3];
  end

  // config writes: either path, local wins a same-cycle clash
  always_comb begin
    cfg_low_next  = cfg_low_reg;
    cfg_high_next = cfg_high_reg;
    if (wr_hit(rem_req, `RGPB_CFG_LOW_OFS)) begin
      cfg_low_next = rem_req.wdata; // R5
    end
    if (wr_hit(loc_req, `RGPB_CFG_LOW_OFS)) begin
      cfg_low_next = loc_req.wdata; // R5
    end
    if (wr_hit(rem_req, `RGPB_CFG_HIGH_OFS)) begin
      cfg_high_next = rem_req.wdata; // R5
    end
    if (wr_hit(loc_req, `RGPB_CFG_HIGH_OFS)) begin
      cfg_high_next = loc_req.wdata; // R5
    end
  end

  // config registers; status registers are read-only, writes dropped
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_low_reg  <= `RGPB_CFG_RST;
      cfg_high_reg <= `RGPB_CFG_RST;
    end else if (ce) begin
      cfg_low_reg  <= cfg_low_next;
      cfg_high_reg <= cfg_high_next;
    end
  end

  // read answers, both paths see the same registers
  always_comb begin
    loc_rsp_next.valid = loc_req.rd;
    loc_rsp_next.data  = read_mux(loc_req.addr, cfg_low_reg,
                                  cfg_high_reg, stat_a, stat_b); // R5
    rem_rsp_next.valid = rem_req.rd;
    rem_rsp_next.data  = read_mux(rem_req.addr, cfg_low_reg,
                                  cfg_high_reg, stat_a, stat_b); // R5
  end

  // answer registers: valid is a one-cycle pulse
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      loc_rsp_reg <= '0;
      rem_rsp_reg <= '0;
    end else if (ce) begin
      loc_rsp_reg <= loc_rsp_next;
      rem_rsp_reg <= rem_rsp_next;
    end
  end

  assign loc_rsp = loc_rsp_reg;
  assign rem_rsp = rem_rsp_reg;

  // one cell per pin; nothing here feeds the serial link, so the
  // pin settings and levels stay inside this device
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin // R6
    rgpb_pin_cell #(
      .SHARED_I2S (I2S_SHARED[i])
    ) u_cell (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .ce      (ce),
      .code    (cfg_all[15-4*i -: 4]),
      .pin_in  (pin_in[i]),
      .pin_out (pin_out[i]),
      .pin_oe  (pin_oe[i]),
      .status  (stat_bits[i]),
      .i2s_in  (i2s_in[i])
    );
  end

  // remote write lands when the local path leaves the register alone
  sequence rem_cfg_wr_s;
    ce && wr_hit(rem_req, `RGPB_CFG_HIGH_OFS) &&
    !wr_hit(loc_req, `RGPB_CFG_HIGH_OFS);
  endsequence
  remote_write_a: assert property ( // R5
    @(posedge ref_clk) disable iff (!nrst)
    rem_cfg_wr_s |=> (cfg_high_reg == $past(rem_req.wdata)))
    else $error("remote config write lost");

  local_write_a: assert property ( // R5
    @(posedge ref_clk) disable iff (!nrst)
    (ce && wr_hit(loc_req, `RGPB_CFG_LOW_OFS))
      |=> (cfg_low_reg == $past(loc_req.wdata)))
    else $error("local config write lost");

  // same address on both paths answers the same data
  paths_agree_a: assert property ( // R5
    @(posedge ref_clk) disable iff (!nrst)
    (ce && loc_req.rd && rem_req.rd && loc_req.addr == rem_req.addr)
      |=> (loc_rsp.valid && rem_rsp.valid &&
           loc_rsp.data == rem_rsp.data))
    else $error("local and remote reads disagree");

  status_map_a: assert property ( // R3
    @(posedge ref_clk) disable iff (!nrst)
    (ce && loc_req.rd && loc_req.addr == `RGPB_STAT_A_OFS)
      |=> (loc_rsp.data[7:5] == $past({stat_bits[1], stat_bits[2],
                                       stat_bits[3]}) &&
           loc_rsp.data[4:0] == 5'h0_0))
    else $error("status a read shows wrong bits");

endmodule

// ---- bench/rgpb_top_bench.sv ----
// self-checking bench for the register-only gpio bank
// assumes rgpb_top with its two register paths, pads tied to the bench
`timescale 1ns/1ps
`include "rgpb_regs.svh"

module rgpb_top_bench;
  logic                ref_clk;      // 125 MHz device clock
  logic                nrst;         // sync reset, active low
  logic                ce;           // clock enable
  rgpb_pkg::rgpb_req_t loc_req;      // local register path
  rgpb_pkg::rgpb_rsp_t loc_rsp;
  rgpb_pkg::rgpb_req_t rem_req;      // remote register path
  rgpb_pkg::rgpb_rsp_t rem_rsp;
  logic [3:0]          pin_in;       // pad levels
  logic [3:0]          pin_out;
  logic [3:0]          pin_oe;
  logic [3:0]          i2s_in;       // audio input after override
  int                  error_cnt;    // mismatches seen
  int                  total_checks; // comparisons made

  rgpb_top u_dut (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .loc_req (loc_req),
    .loc_rsp (loc_rsp),
    .rem_req (rem_req),
    .rem_rsp (rem_rsp),
    .pin_in  (pin_in),
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .i2s_in  (i2s_in)
  );

  // free-running clock, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // one comparison, counted, reported on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // puts one request on the chosen path (1 = remote)
  task automatic drv(input bit p, input logic w, input logic r,
                     input logic [7:0] a, input logic [7:0] d);
    rgpb_pkg::rgpb_req_t q;
    // member by member: the task names wr and rd shadow pattern keys
    q.wr    = w;
    q.rd    = r;
    q.addr  = a;
    q.wdata = d;
    if (p) begin
      rem_req = q;
    end else begin
      loc_req = q;
    end
  endtask

  // one-cycle write strobe; value visible after the next edge
  task automatic wr(input bit p, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    drv(p, 1'b1, 1'b0, a, d);
    @(negedge ref_clk);
    drv(p, 1'b0, 1'b0, a, d);
  endtask

  // one-cycle read strobe, answer pulse checked in the following cycle
  task automatic rd(input bit p, input logic [7:0] a, input logic [7:0] e);
    rgpb_pkg::rgpb_rsp_t s;
    @(negedge ref_clk);
    drv(p, 1'b0, 1'b1, a, 8'h00);
    @(negedge ref_clk);
    drv(p, 1'b0, 1'b0, a, 8'h00);
    s = p ? rem_rsp : loc_rsp;
    chk({7'h00, s.valid}, 8'h01);
    chk(s.data, e);
    @(negedge ref_clk);
    s = p ? rem_rsp : loc_rsp;
    chk({7'h00, s.valid}, 8'h00);
  endtask

  // reset state: config undriven, status clear
  task automatic t_reset;
    chk({4'h0, pin_oe}, 8'h00);
    rd(1'b0, `RGPB_CFG_LOW_OFS, 8'h00);
    rd(1'b1, `RGPB_CFG_HIGH_OFS, 8'h00);
    rd(1'b0, `RGPB_STAT_A_OFS, 8'h00);
    rd(1'b1, `RGPB_STAT_B_OFS, 8'h00);
  endtask

  // every code on every pin, then a mixed per-pin pattern
  task automatic t_codes;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(i[0], `RGPB_CFG_LOW_OFS, {c, c});
      wr(i[1], `RGPB_CFG_HIGH_OFS, {c, c});
      chk({4'h0, pin_oe}, (c == 4'h1 || c == 4'h9) ? 8'h0f : 8'h00);
      if (c == 4'h1 || c == 4'h9) begin
        chk({4'h0, pin_out}, (c == 4'h9) ? 8'h0f : 8'h00);
      end
      rd(~i[0], `RGPB_CFG_HIGH_OFS, {c, c});
    end
    // pin0 high, pin1 low, pin2 low, pin3 high
    wr(1'b0, `RGPB_CFG_HIGH_OFS, 8'h91);
    wr(1'b1, `RGPB_CFG_LOW_OFS, 8'h19);
    chk({4'h0, pin_oe}, 8'h0f);
    chk({4'h0, pin_out}, 8'h09);
  endtask

  // all pins as inputs: status bits and audio override
  task automatic t_inputs;
    logic [3:0] v;
    wr(1'b1, `RGPB_CFG_HIGH_OFS, 8'h33);
    wr(1'b1, `RGPB_CFG_LOW_OFS, 8'h33);
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      pin_in = v;
      repeat (4) @(negedge ref_clk);
      chk({4'h0, pin_oe}, 8'h00);
      chk({4'h0, i2s_in}, 8'h00);
      rd(i[0], `RGPB_STAT_A_OFS, {v[1], v[2], v[3], 5'h00});
      rd(~i[0], `RGPB_STAT_B_OFS, {7'h00, v[0]});
    end
    // pin0 and pin3 inputs, pins 1 and 2 back to audio
    wr(1'b0, `RGPB_CFG_HIGH_OFS, 8'h30);
    wr(1'b0, `RGPB_CFG_LOW_OFS, 8'h03);
    pin_in = 4'hf;
    repeat (4) @(negedge ref_clk);
    chk({4'h0, i2s_in}, 8'h06);
    rd(1'b1, `RGPB_STAT_A_OFS, 8'h20);
    rd(1'b0, `RGPB_STAT_B_OFS, 8'h01);
    // all off: audio sees the pads again, status clear
    wr(1'b0, `RGPB_CFG_HIGH_OFS, 8'h00);
    wr(1'b0, `RGPB_CFG_LOW_OFS, 8'h00);
    pin_in = 4'ha;
    repeat (4) @(negedge ref_clk);
    chk({4'h0, i2s_in}, 8'h0a);
    rd(1'b1, `RGPB_STAT_A_OFS, 8'h00);
  endtask

  // path clash, read-only and unmapped writes, frozen enable
  task automatic t_refuse;
    @(negedge ref_clk);
    drv(1'b0, 1'b1, 1'b0, `RGPB_CFG_LOW_OFS, 8'h19);
    drv(1'b1, 1'b1, 1'b0, `RGPB_CFG_LOW_OFS, 8'h91);
    @(negedge ref_clk);
    drv(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    drv(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
    rd(1'b1, `RGPB_CFG_LOW_OFS, 8'h19);
    // both paths read one register in the same cycle
    @(negedge ref_clk);
    drv(1'b0, 1'b0, 1'b1, `RGPB_CFG_LOW_OFS, 8'h00);
    drv(1'b1, 1'b0, 1'b1, `RGPB_CFG_LOW_OFS, 8'h00);
    @(negedge ref_clk);
    drv(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    drv(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({7'h00, loc_rsp.valid}, 8'h01);
    chk({7'h00, rem_rsp.valid}, 8'h01);
    chk(loc_rsp.data, 8'h19);
    chk(rem_rsp.data, 8'h19);
    wr(1'b1, `RGPB_STAT_A_OFS, 8'hff);
    wr(1'b0, 8'h20, 8'hff);
    rd(1'b0, `RGPB_STAT_A_OFS, 8'h00);
    rd(1'b1, 8'h20, 8'h00);
    ce = 1'b0;
    wr(1'b0, `RGPB_CFG_LOW_OFS, 8'h55);
    ce = 1'b1;
    rd(1'b0, `RGPB_CFG_LOW_OFS, 8'h19);
  endtask

  // verdict and end of run
  task automatic end_of_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog, well beyond the few hundred cycles the tests take
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  // main sequence
  initial begin
    error_cnt    = 0;
    total_checks = 0;
    nrst         = 1'b0;
    ce           = 1'b1;
    pin_in       = 4'h0;
    loc_req      = '0;
    rem_req      = '0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset();
    t_codes();
    t_inputs();
    t_refuse();
    end_of_test();
  end
endmodule
